/* File: logic/apc_pkg.sv */
// Purpose: Shared constants for the converter power-state and coding block.
// Assumes: ref_clk at 250 MHz; two-wire pins sampled synchronously.
// Notes:   Figures here are used by every design file of the block.
package apc_pkg;

   // Reference clock and internal conversion clock rates
   localparam int unsigned REF_CLK_KHZ    = 250000;
   localparam int unsigned CONV_CLK_KHZ   = 1560;
   // Reference clock cycles per conversion clock, rounded down
   localparam int unsigned CONV_TICK_DIV  = REF_CLK_KHZ / CONV_CLK_KHZ;
   // Conversion clocks that make up one conversion
   localparam int unsigned CONV_TICKS     = 12;

   // Result and control widths
   localparam int unsigned RES_W          = 12;
   localparam int unsigned BYTE_W         = 8;

   // Fixed upper part of the 7-bit slave address
   localparam logic [3:0]  SLAVE_ADDR_HI  = 4'h5;

   // Control byte field positions
   localparam int unsigned CTL_START_BIT  = 7;
   localparam int unsigned CTL_CHAN_LSB   = 4;
   localparam int unsigned CTL_RANGE_BIT  = 3;
   localparam int unsigned CTL_POL_BIT    = 2;
   localparam int unsigned CTL_PD_HI_BIT  = 1;
   localparam int unsigned CTL_PD_LO_BIT  = 0;

   // Values after reset
   localparam logic [7:0]  CTL_RESET      = 8'h00;
   localparam logic [11:0] RES_RESET      = 12'h000;

   // Bits per byte, acknowledge slot not counted
   localparam logic [3:0]  BITS_PER_BYTE  = 4'h8;

   // Power states
   typedef enum logic [1:0] {
      APC_PWR_NORMAL,
      APC_PWR_STANDBY,
      APC_PWR_FULL
   } apc_pwr_t;

   // Serial slave states
   typedef enum logic [2:0] {
      APC_SS_IDLE,
      APC_SS_ADDR,
      APC_SS_ADDR_ACK,
      APC_SS_WDATA,
      APC_SS_WDATA_ACK,
      APC_SS_RDATA,
      APC_SS_RACK
   } apc_ser_t;

endpackage : apc_pkg

/* File: logic/apc_tick.sv */
// Purpose: Conversion clock enable, one pulse every DIV reference cycles.
// Assumes: clr restarts the period so a conversion begins on a full period.
// Notes:   Pulse is one ref_clk cycle wide.
module apc_tick #(
   parameter int unsigned DIV = apc_pkg::CONV_TICK_DIV
) (
   // Clock and reset
   input  wire logic ref_clk,
   input  wire logic rst,
   // Control and pulse
   input  wire logic clr,
   output logic      tick
);

   localparam int unsigned CW = $clog2(DIV + 1);

   // Elaboration check: a period below two cycles cannot wrap
   if (DIV < 2) begin : g_bad_div
      $error("apc_tick: DIV must be at least 2");
   end

   logic [CW-1:0] cnt_q;
   logic [CW-1:0] cnt_d;
   wire           wrap = (cnt_q == CW'(DIV - 1));

   // Next count wraps at the end of each period
   assign cnt_d = (clr | wrap) ? '0 : cnt_q + CW'(1);
   assign tick  = wrap & ~clr;

   // Period counter
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_d;
      end
   end

endmodule : apc_tick

/* File: logic/apc_coder.sv */
// Purpose: Turns the raw offset-binary converter code into the output code.
// Assumes: raw code 0 is negative full scale in bipolar, zero in unipolar.
// Notes:   Purely combinational; the caller registers the result.
module apc_coder #(
   parameter int unsigned W = apc_pkg::RES_W
) (
   // Raw code and mode
   input  wire logic [W-1:0] raw,
   input  wire logic         bipolar,
   // Coded result
   output logic      [W-1:0] coded
);

   // Elaboration check: a sign bit needs at least one bit below it
   if (W < 2) begin : g_bad_w
      $error("apc_coder: W must be at least 2");
   end

   // Unipolar passes straight binary; bipolar flips the sign bit
   assign coded = bipolar ? {~raw[W-1], raw[W-2:0]} : raw;

endmodule : apc_coder

/* File: logic/apc_ctrl.sv */
// Purpose: Power-state control, two-wire slave port and result coding of a
//          12-bit acquisition converter.
// Assumes: scl_i/sda_i are already synchronous to ref_clk and are slow
//          against it; the analog core presents raw_code at end of conversion.
// Notes:   sda is open drain: the block only ever pulls the line low.
//
// How it works
// - Reset leaves normal power, slave idle.
// - Reset clears control byte and result.
// - Power-down select bits pick standby or full.
// - Software power-down waits for conversion end.
// - Slave port runs in every power state.
// - Address match with write wakes next bit.
// - Shutdown pin forces full power-down, aborts.
// - Standby keeps buffer; full keeps bandgap only.
// - Standby each conversion auto-sleeps, no restart delay.
// - Unipolar result is straight binary.
// - Bipolar result is two's complement.
// - Select hi 0 normal, 10 standby, 11 full.
// - Control bit 2 chooses unipolar or bipolar.
// - Read sends bits 11-4, then 3-0, zeros.
// - Conversion starts at stop, conversion clock timed.
module apc_ctrl #(
   parameter int unsigned CONV_DIV   = apc_pkg::CONV_TICK_DIV,
   parameter int unsigned CONV_TICKS = apc_pkg::CONV_TICKS
) (
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rst,
   // Two-wire serial slave pins
   input  wire logic        scl_i,
   input  wire logic        sda_i,
   output logic             sda_o,
   output logic             sda_oe,
   input  wire logic [2:0]  addr_pins,
   // Hardware shutdown, active low
   input  wire logic        hw_shutdown_n,
   // Analog core interface
   input  wire logic [11:0] raw_code,
   output logic [2:0]       channel_select,
   output logic             range_select,
   output logic             polarity_select,
   output logic             acquire,
   output logic             conv_busy,
   // Power status and reference enables
   output logic             standby_powerdown,
   output logic             full_powerdown,
   output logic             bandgap_en,
   output logic             ref_buffer_en,
   // Stored result
   output logic [11:0]      result
);

   // Elaboration check: the conversion tick counter is eight bits wide
   if (CONV_TICKS < 1 || CONV_TICKS > 255) begin : g_bad_ticks
      $error("apc_ctrl: CONV_TICKS must be 1 to 255");
   end

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   apc_pkg::apc_ser_t ser_q, ser_d;
   apc_pkg::apc_pwr_t pwr_q, pwr_d;
   logic [7:0]  rx_q, rx_d;
   logic [7:0]  tx_q, tx_d;
   logic [3:0]  bit_q, bit_d;
   logic        rw_q, rw_d;
   logic        byte2_q, byte2_d;
   logic        scl_q;
   logic        sda_q;
   logic        hw_shutdown_n_q;
   logic [7:0]  ctl_q, ctl_d;
   logic        got_ctl_q, got_ctl_d;
   logic        busy_q, busy_d;
   logic [7:0]  tcnt_q, tcnt_d;
   logic        pend_q, pend_d;
   logic [11:0] res_q, res_d;

   // ---------------------------------------------------------------
   // Bus event decode
   // ---------------------------------------------------------------
   wire scl_rise   = scl_i & ~scl_q;
   wire scl_fall   = ~scl_i & scl_q;
   wire bus_start  = scl_i & scl_q & sda_q & ~sda_i;
   wire bus_stop   = scl_i & scl_q & ~sda_q & sda_i;
   wire byte_done  = (bit_q == apc_pkg::BITS_PER_BYTE);
   wire addr_hit   = (rx_q[7:1] == {apc_pkg::SLAVE_ADDR_HI, addr_pins});
   wire hw_shutdown_n_act   = ~hw_shutdown_n;
   wire hw_shutdown_n_rel   = hw_shutdown_n & ~hw_shutdown_n_q;

   // Wake on the bit after an address match with write direction
   wire wake       = (ser_q == apc_pkg::APC_SS_ADDR_ACK) & ~rw_q & scl_rise;

   // Read bytes: high bits first, then low bits padded with zeros
   wire [7:0] rd_hi = res_q[11:4];
   wire [7:0] rd_lo = {res_q[3:0], 4'h0};

   // Control byte fields
   wire       pd_hi  = ctl_q[apc_pkg::CTL_PD_HI_BIT];
   wire       pd_lo  = ctl_q[apc_pkg::CTL_PD_LO_BIT];
   wire [7:0] rx_new = rx_d;

   // Conversion clock
   logic conv_tick;
   wire  conv_start = bus_stop & got_ctl_q & hw_shutdown_n;
   wire  conv_end   = busy_q & conv_tick & (tcnt_q == 8'(CONV_TICKS - 1));

   apc_tick #(
      .DIV     (CONV_DIV)
   ) u_tick (
      .ref_clk (ref_clk),
      .rst     (rst),
      .clr     (conv_start),
      .tick    (conv_tick)
   );

   // Output coding follows the stored polarity bit
   logic [11:0] coded;

   apc_coder #(
      .W       (apc_pkg::RES_W)
   ) u_coder (
      .raw     (raw_code),
      .bipolar (ctl_q[apc_pkg::CTL_POL_BIT]),
      .coded   (coded)
   );

   // ---------------------------------------------------------------
   // Serial slave next state; kept alive in every power state
   // ---------------------------------------------------------------
   always_comb begin
      ser_d     = ser_q;
      rx_d      = rx_q;
      tx_d      = tx_q;
      bit_d     = bit_q;
      rw_d      = rw_q;
      byte2_d   = byte2_q;
      ctl_d     = ctl_q;
      got_ctl_d = got_ctl_q;
      if (scl_rise && (ser_q == apc_pkg::APC_SS_ADDR || ser_q == apc_pkg::APC_SS_WDATA)) begin
         rx_d  = {rx_q[6:0], sda_i};
         bit_d = bit_q + 4'h1;
      end else if (scl_rise && ser_q == apc_pkg::APC_SS_RDATA) begin
         bit_d = bit_q + 4'h1;
      end
      if (bus_start) begin
         ser_d     = apc_pkg::APC_SS_ADDR;
         bit_d     = 4'h0;
         got_ctl_d = 1'b0;
      end else if (bus_stop) begin
         ser_d     = apc_pkg::APC_SS_IDLE;
         got_ctl_d = 1'b0;
      end else if (scl_fall) begin
         unique case (ser_q)
            apc_pkg::APC_SS_IDLE: begin
               ser_d = apc_pkg::APC_SS_IDLE;
            end
            apc_pkg::APC_SS_ADDR: begin
               if (byte_done) begin
                  ser_d = addr_hit ? apc_pkg::APC_SS_ADDR_ACK : apc_pkg::APC_SS_IDLE;
                  rw_d  = rx_q[0];
               end
            end
            apc_pkg::APC_SS_ADDR_ACK: begin
               bit_d   = 4'h0;
               byte2_d = 1'b0;
               tx_d    = rd_hi;
               ser_d   = rw_q ? apc_pkg::APC_SS_RDATA : apc_pkg::APC_SS_WDATA;
            end
            apc_pkg::APC_SS_WDATA: begin
               if (byte_done) begin
                  ser_d = apc_pkg::APC_SS_WDATA_ACK;
                  // A byte counts as control only when its top bit is set
                  if (rx_new[apc_pkg::CTL_START_BIT]) begin
                     ctl_d     = rx_new;
                     got_ctl_d = 1'b1;
                  end
               end
            end
            apc_pkg::APC_SS_WDATA_ACK: begin
               bit_d = 4'h0;
               ser_d = apc_pkg::APC_SS_WDATA;
            end
            apc_pkg::APC_SS_RDATA: begin
               if (byte_done) begin
                  ser_d = apc_pkg::APC_SS_RACK;
               end else begin
                  tx_d = {tx_q[6:0], 1'b0};
               end
            end
            apc_pkg::APC_SS_RACK: begin
               // Acknowledge asks for the next byte, alternating hi and lo;
               // a not-acknowledge frees the line so the master can stop
               bit_d   = 4'h0;
               byte2_d = ~byte2_q;
               tx_d    = byte2_q ? rd_hi : rd_lo;
               ser_d   = sda_q ? apc_pkg::APC_SS_IDLE : apc_pkg::APC_SS_RDATA;
            end
            default: begin
               ser_d = apc_pkg::APC_SS_IDLE;
            end
         endcase
      end
   end

   // Open-drain drive: acknowledge slots and zero data bits pull low
   assign sda_o  = 1'b0;
   assign sda_oe = (ser_q == apc_pkg::APC_SS_ADDR_ACK) |
                   (ser_q == apc_pkg::APC_SS_WDATA_ACK) |
                   ((ser_q == apc_pkg::APC_SS_RDATA) & ~tx_q[7]);

   // ---------------------------------------------------------------
   // Conversion sequencing
   // ---------------------------------------------------------------
   always_comb begin
      busy_d = busy_q;
      tcnt_d = tcnt_q;
      res_d  = res_q;
      if (hw_shutdown_n_act) begin
         busy_d = 1'b0;
         tcnt_d = 8'h00;
      end else if (conv_start) begin
         busy_d = 1'b1;
         tcnt_d = 8'h00;
      end else if (conv_end) begin
         busy_d = 1'b0;
         res_d  = coded;
      end else if (busy_q && conv_tick) begin
         tcnt_d = tcnt_q + 8'h01;
      end
   end

   // ---------------------------------------------------------------
   // Power state: pending software request, wake and shutdown
   // ---------------------------------------------------------------
   always_comb begin
      pwr_d  = pwr_q;
      pend_d = pend_q;
      if (hw_shutdown_n_act) begin
         pwr_d  = apc_pkg::APC_PWR_FULL;
         pend_d = 1'b0;
      end else if (hw_shutdown_n_rel) begin
         pwr_d  = apc_pkg::APC_PWR_NORMAL;
      end else if (wake) begin
         pwr_d  = apc_pkg::APC_PWR_NORMAL;
         pend_d = 1'b0;
      end else if (conv_start) begin
         pend_d = pd_hi;
      end else if (conv_end && pend_q) begin
         // Standby each time gives automatic sleep after every result
         pwr_d  = pd_lo ? apc_pkg::APC_PWR_FULL : apc_pkg::APC_PWR_STANDBY;
         pend_d = 1'b0;
      end
   end

   // Reference enables per power state
   assign bandgap_en        = 1'b1;
   assign ref_buffer_en     = (pwr_q != apc_pkg::APC_PWR_FULL);
   assign standby_powerdown = (pwr_q == apc_pkg::APC_PWR_STANDBY);
   assign full_powerdown    = (pwr_q == apc_pkg::APC_PWR_FULL);

   // Analog core selects straight from the stored control byte; acquire, busy and result from their own registers
   assign channel_select  = ctl_q[apc_pkg::CTL_CHAN_LSB +: 3];
   assign range_select    = ctl_q[apc_pkg::CTL_RANGE_BIT];
   assign polarity_select = ctl_q[apc_pkg::CTL_POL_BIT];
   assign acquire         = got_ctl_q;
   assign conv_busy       = busy_q;
   assign result          = res_q;

   // Serial slave registers
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ser_q   <= apc_pkg::APC_SS_IDLE;
         rx_q    <= 8'h00;
         tx_q    <= 8'h00;
         bit_q   <= 4'h0;
         rw_q    <= 1'b0;
         byte2_q <= 1'b0;
         scl_q   <= 1'b1;
         sda_q   <= 1'b1;
      end else begin
         ser_q   <= ser_d;
         rx_q    <= rx_d;
         tx_q    <= tx_d;
         bit_q   <= bit_d;
         rw_q    <= rw_d;
         byte2_q <= byte2_d;
         scl_q   <= scl_i;
         sda_q   <= sda_i;
      end
   end

   // Control, conversion and power registers
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ctl_q     <= apc_pkg::CTL_RESET;
         res_q     <= apc_pkg::RES_RESET;
         got_ctl_q <= 1'b0;
         busy_q    <= 1'b0;
         tcnt_q    <= 8'h00;
         pend_q    <= 1'b0;
         pwr_q     <= apc_pkg::APC_PWR_NORMAL;
         hw_shutdown_n_q    <= 1'b1;
      end else begin
         ctl_q     <= ctl_d;
         res_q     <= res_d;
         got_ctl_q <= got_ctl_d;
         busy_q    <= busy_d;
         tcnt_q    <= tcnt_d;
         pend_q    <= pend_d;
         pwr_q     <= pwr_d;
         hw_shutdown_n_q    <= hw_shutdown_n;
      end
   end

endmodule : apc_ctrl

/* File: tb/apc_ctrl_assertions.sv */
// Purpose: Port-level checks of the power-state and coding block.
// Assumes: One ref_clk domain, rst asynchronous and active high.
// Notes:   Bound to every instance of the block.
module apc_chk #(
   parameter int unsigned CONV_DIV   = apc_pkg::CONV_TICK_DIV,
   parameter int unsigned CONV_TICKS = apc_pkg::CONV_TICKS
) (
   // Clock and reset
   input wire logic        ref_clk,
   input wire logic        rst,
   // Serial pins
   input wire logic        scl_i,
   input wire logic        sda_i,
   input wire logic        sda_o,
   input wire logic        sda_oe,
   input wire logic [2:0]  addr_pins,
   // Shutdown and core
   input wire logic        hw_shutdown_n,
   input wire logic [11:0] raw_code,
   input wire logic [2:0]  channel_select,
   input wire logic        range_select,
   input wire logic        polarity_select,
   input wire logic        acquire,
   input wire logic        conv_busy,
   // Power and result
   input wire logic        standby_powerdown,
   input wire logic        full_powerdown,
   input wire logic        bandgap_en,
   input wire logic        ref_buffer_en,
   input wire logic [11:0] result
);
   localparam int CMIN = CONV_DIV * (CONV_TICKS - 1) + 1;
   localparam int CMAX = CONV_DIV * (CONV_TICKS + 1);
   logic [15:0] busy_cnt_q;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   // Cycles spent busy in the running conversion
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) busy_cnt_q <= 16'h0000;
      else busy_cnt_q <= conv_busy ? busy_cnt_q + 16'h0001 : 16'h0000;
   end
   // A conversion that ran to its end, not aborted
   sequence s_conv_done;
      $fell(conv_busy) && hw_shutdown_n && $past(hw_shutdown_n);
   endsequence
   property p_conv_len;
      s_conv_done |-> busy_cnt_q >= CMIN;
   endproperty
   a_conv_len: assert property (p_conv_len) else $error("conversion too short");
   property p_conv_max;
      busy_cnt_q <= CMAX;
   endproperty
   a_conv_max: assert property (p_conv_max) else $error("conversion too long");
   property p_bg;
      bandgap_en;
   endproperty
   a_bg: assert property (p_bg) else $error("bandgap off");
   property p_buf;
      ref_buffer_en == !full_powerdown;
   endproperty
   a_buf: assert property (p_buf) else $error("buffer enable wrong");
   property p_excl;
      !(standby_powerdown && full_powerdown);
   endproperty
   a_excl: assert property (p_excl) else $error("two power states");
   property p_hw_shutdown_n;
      !hw_shutdown_n |=> full_powerdown && !conv_busy;
   endproperty
   a_hw_shutdown_n: assert property (p_hw_shutdown_n) else $error("shutdown not immediate");
   property p_rel;
      $rose(hw_shutdown_n) |=> !full_powerdown && !standby_powerdown;
   endproperty
   a_rel: assert property (p_rel) else $error("no normal after shutdown");
   property p_busy_pd;
      conv_busy |-> !standby_powerdown && !full_powerdown;
   endproperty
   a_busy_pd: assert property (p_busy_pd) else $error("asleep while busy");
   property p_sb_entry;
      $rose(standby_powerdown) |-> $past(conv_busy) || $past(conv_busy, 2);
   endproperty
   a_sb_entry: assert property (p_sb_entry) else $error("standby not at end");
   property p_res;
      $changed(result) |-> $fell(conv_busy);
   endproperty
   a_res: assert property (p_res) else $error("result moved mid run");
   property p_acq;
      !(acquire && conv_busy);
   endproperty
   a_acq: assert property (p_acq) else $error("acquire during conversion");
endmodule : apc_chk

bind apc_ctrl apc_chk #(.CONV_DIV(CONV_DIV), .CONV_TICKS(CONV_TICKS)) u_chk (
   .ref_clk, .rst, .scl_i, .sda_i, .sda_o, .sda_oe, .addr_pins,
   .hw_shutdown_n, .raw_code, .channel_select, .range_select,
   .polarity_select, .acquire, .conv_busy, .standby_powerdown,
   .full_powerdown, .bandgap_en, .ref_buffer_en, .result
);

/* File: tb/apc_master.sv */
// Purpose: Two-wire bus master that drives the block's serial port.
// Assumes: H ref_clk cycles per bus clock phase.
// Notes:   Line is wired-AND with a pull-up.
module apc_master #(
   parameter int H = 8
) (
   // Clock and device pull-down
   input wire logic ref_clk,
   input wire logic dev_oe,
   // Bus lines
   output logic     scl,
   output logic     sda
);
   timeunit 1ns;
   timeprecision 100ps;
   logic pull_q;
   // Pull-up wins unless someone pulls low
   assign sda = !(pull_q || dev_oe);
   initial begin
      scl = 1'b1;
      pull_q = 1'b0;
   end
   task automatic hold(input int n);
      repeat (n) @(posedge ref_clk);
   endtask : hold
   // One bus clock: data set while low, sampled while high
   task automatic bit_x(input logic b, output logic got);
      @(posedge ref_clk);
      pull_q <= !b;
      hold(H);
      scl <= 1'b1;
      hold(H);
      got = sda;
      scl <= 1'b0;
   endtask : bit_x
   task automatic start();
      @(posedge ref_clk);
      pull_q <= 1'b0;
      hold(H);
      scl <= 1'b1;
      hold(H);
      pull_q <= 1'b1;
      hold(H);
      scl <= 1'b0;
   endtask : start
   task automatic stop();
      @(posedge ref_clk);
      pull_q <= 1'b1;
      hold(H);
      scl <= 1'b1;
      hold(H);
      pull_q <= 1'b0;
      hold(2);
   endtask : stop
   task automatic wr_byte(input logic [7:0] b, output logic ack);
      logic g;
      for (int i = 7; i >= 0; i--) bit_x(b[i], g);
      bit_x(1'b1, g);
      ack = !g;
   endtask : wr_byte
   task automatic rd_byte(input logic nak, output logic [7:0] b);
      logic g;
      for (int i = 7; i >= 0; i--) begin
         bit_x(1'b1, g);
         b[i] = g;
      end
      bit_x(nak, g);
   endtask : rd_byte
endmodule : apc_master

/* File: tb/tb_top.sv */
// Purpose: Self-checking bench of the power-state and coding block.
// Assumes: Short conversion parameters keep the run brief.
// Notes:   Checks that follow st() are made one step after a clock edge.
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [2:0] ADDR = 3'h6;
   localparam logic [6:0] DEV  = {apc_pkg::SLAVE_ADDR_HI, ADDR};
   logic        ref_clk, rst, hw_shutdown_n, scl, sda, sda_o, sda_oe, ack;
   logic        range_select, polarity_select, acquire, conv_busy, bandgap_en;
   logic        standby_powerdown, full_powerdown, ref_buffer_en;
   logic [2:0]  channel_select;
   logic [11:0] raw_code, result;
   logic [7:0]  b0, b1;
   int          mismatches, num_checks;
   // Block under test
   apc_ctrl #(.CONV_DIV(4), .CONV_TICKS(2)) DUT (
      .ref_clk, .rst, .scl_i(scl), .sda_i(sda), .sda_o, .sda_oe,
      .addr_pins(ADDR), .hw_shutdown_n, .raw_code, .channel_select,
      .range_select, .polarity_select, .acquire, .conv_busy,
      .standby_powerdown, .full_powerdown, .bandgap_en, .ref_buffer_en, .result
   );
   // Far-side bus master
   apc_master #(.H(8)) BUS (.ref_clk, .dev_oe(sda_oe), .scl, .sda);
   // 250 MHz clock
   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end
   task automatic st(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : st
   task automatic complete_run();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : complete_run
   task automatic chk_w(input logic [11:0] got, input logic [11:0] exp, input string m);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask : chk_w
   task automatic chk_b(input logic got, input logic exp, input string m);
      chk_w({11'h000, got}, {11'h000, exp}, m);
   endtask : chk_b
   // Address, control byte, stop; conversion must then run
   task automatic wr_ctl(input logic [7:0] c);
      BUS.start();
      BUS.wr_byte({DEV, 1'b0}, ack);
      chk_b(ack, 1'b1, "addr ack");
      BUS.wr_byte(c, ack);
      chk_b(ack, 1'b1, "ctl ack");
      chk_b(acquire, 1'b1, "acquire");
      BUS.stop();
      st(1);
      chk_b(conv_busy, 1'b1, "busy");
      chk_b(acquire, 1'b0, "acq end");
   endtask : wr_ctl
   task automatic rd_chk(input logic [11:0] exp);
      BUS.start();
      BUS.wr_byte({DEV, 1'b1}, ack);
      chk_b(ack, 1'b1, "read ack");
      BUS.rd_byte(1'b0, b0);
      BUS.rd_byte(1'b1, b1);
      BUS.stop();
      chk_b(sda_oe, 1'b0, "released");
      chk_w({4'h0, b0}, {4'h0, exp[11:4]}, "byte hi");
      chk_w({4'h0, b1}, {4'h0, exp[3:0], 4'h0}, "byte lo");
   endtask : rd_chk
   task automatic wait_conv();
      int i;
      i = 0;
      while (conv_busy !== 1'b0 && i < 200) begin
         st(1);
         i++;
      end
      if (i == 200) begin
         mismatches++;
         $display("CHECK FAILED at %0t: conversion hang", $time);
         complete_run();
      end
      st(2);
   endtask : wait_conv
   // Main sequence
   initial begin
      rst = 1'b1;
      hw_shutdown_n = 1'b1;
      raw_code = 12'h000;
      mismatches = 0;
      num_checks = 0;
      repeat (20) @(posedge ref_clk);
      rst <= 1'b0;
      st(2);
      chk_b(standby_powerdown | full_powerdown, 1'b0, "power");
      chk_w(result, 12'h000, "result");
      chk_w({9'h000, channel_select}, 12'h000, "ctl");
      chk_b(sda_o, 1'b0, "open drain");
      BUS.start();
      BUS.wr_byte({apc_pkg::SLAVE_ADDR_HI, ~ADDR, 1'b0}, ack);
      BUS.stop();
      chk_b(ack, 1'b0, "foreign ack");
      rd_chk(12'h000);
      @(posedge ref_clk);
      raw_code <= 12'hA5C;
      wr_ctl(8'hB2);
      chk_w({9'h000, channel_select}, 12'h003, "chan");
      chk_b(polarity_select, 1'b0, "unipolar");
      wait_conv();
      chk_w(result, 12'hA5C, "straight");
      chk_b(standby_powerdown, 1'b1, "standby");
      chk_b(ref_buffer_en, 1'b1, "buf standby");
      rd_chk(12'hA5C);
      chk_b(standby_powerdown, 1'b1, "read keeps");
      BUS.start();
      BUS.wr_byte({DEV, 1'b0}, ack);
      st(1);
      chk_b(standby_powerdown, 1'b0, "wake");
      BUS.stop();
      @(posedge ref_clk);
      raw_code <= 12'h123;
      wr_ctl(8'h87);
      chk_b(polarity_select, 1'b1, "bipolar");
      wait_conv();
      chk_w(result, 12'h923, "twos");
      chk_b(full_powerdown, 1'b1, "full");
      chk_b(ref_buffer_en, 1'b0, "buf full");
      wr_ctl(8'h89);
      chk_b(range_select, 1'b1, "range");
      wait_conv();
      chk_w(result, 12'h123, "unipolar");
      chk_b(standby_powerdown | full_powerdown, 1'b0, "normal");
      @(posedge ref_clk);
      raw_code <= 12'hFFF;
      wr_ctl(8'h86);
      @(posedge ref_clk);
      hw_shutdown_n <= 1'b0;
      st(2);
      chk_b(full_powerdown, 1'b1, "shutdown");
      chk_b(conv_busy, 1'b0, "abort");
      chk_w(result, 12'h123, "kept");
      rd_chk(12'h123);
      @(posedge ref_clk);
      hw_shutdown_n <= 1'b1;
      st(20);
      chk_b(standby_powerdown | full_powerdown, 1'b0, "override");
      complete_run();
   end
endmodule : tb_top
